// file: timer2_pkg.sv
// constants for the timer 2 register side: offsets, bit positions, resets
// assumes a byte-wide cpu data bus with separate data-space and short i/o strobes
package timer2_pkg;
   localparam logic [15:0] OFF_FLAGS = 16'h0037;
   localparam logic [15:0] OFF_SYNC = 16'h0043;
   localparam logic [15:0] OFF_MASK = 16'h0070;
   localparam logic [15:0] OFF_CTRLA = 16'h00b0;
   localparam logic [15:0] OFF_CTRLB = 16'h00b1;
   localparam logic [15:0] OFF_CNT = 16'h00b2;
   localparam logic [15:0] OFF_CMPA = 16'h00b3;
   localparam logic [15:0] OFF_CMPB = 16'h00b4;
   localparam logic [15:0] OFF_ASYNC = 16'h00b6;
   localparam logic [15:0] IO_SHIFT = 16'h0020;
   localparam logic [15:0] EXT_BASE = 16'h0060;
   localparam int BIT_WRAP = 0;
   localparam int BIT_MATCH_A = 1;
   localparam int BIT_MATCH_B = 2;
   localparam int BIT_AS = 5;
   localparam int BIT_EXT = 6;
   localparam int BIT_TSM = 7;
   localparam int BIT_PSR_ASY = 1;
   localparam int BIT_PSR_SYNC = 0;
   localparam int NUM_BUSY = 5;
   localparam int BUSY_CTRLB = 0;
   localparam int BUSY_CTRLA = 1;
   localparam int BUSY_CMPB = 2;
   localparam int BUSY_CMPA = 3;
   localparam int BUSY_CNT = 4;
   // offset of the register behind each busy bit, indexed by busy bit
   localparam logic [NUM_BUSY-1:0][15:0] BUSY_OFFS = {OFF_CNT, OFF_CMPA, OFF_CMPB, OFF_CTRLA, OFF_CTRLB};
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_FLAGS = 3'h0;
   localparam logic [2:0] RST_MASK = 3'h0;
endpackage

// file: timer2_busy_slot.sv
// one update-busy bit for an asynchronously updated timer register
// assumes tick is a one-cycle pulse per timer clock, synchronous to clk
`timescale 1ns/1ps
module timer2_busy_slot (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic async_mode,
   input wire logic wr,
   input wire logic tick,
   output logic busy_q
);
   typedef struct packed {
      logic busy;
   } slot_s;
   slot_s q;
   slot_s d;

   always_comb begin
      d = q;
      if (!async_mode) begin
         d.busy = 1'b0;
      end else if (wr) begin
         // a write in the tick cycle keeps the slot busy for the next transfer
         d.busy = 1'b1; // R13
      end else if (tick) begin
         d.busy = 1'b0; // R13
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign busy_q = q.busy;
endmodule // timer2_busy_slot

// file: timer2_regs.sv
// timer 2 register side: compare b, irq mask and flags, async status, sync control
// assumes the counting engine supplies counter value, events and timer ticks on clk
//
// Function
// [R1] hold compare b, match on timer tick
// [R2] mask bit 2 gates compare b irq
// [R3] mask bit 1 gates compare a irq
// [R4] mask bit 0 gates overflow irq
// [R5] compare a match sets flag bit 1
// [R6] compare b match sets flag bit 2
// [R7] overflow sets bit 0; dual slope at bottom
// [R8] flags clear on vector or written one
// [R9] external clock buffer replaces crystal when selected
// [R10] software selects external clock before async
// [R11] async select chooses oscillator timer clock
// [R12] async select change needs register reinit
// [R13] async writes set busy until transfer
// [R14] software waits for busy clear before writing
// [R15] short i/o address is offset minus 0x20
// [R16] extended space only by data-space access
// [R17] sync mode holds both prescaler resets
// [R18] clearing sync mode releases both resets
// [R19] sync prescaler reset self-clears outside sync mode
`timescale 1ns/1ps
module timer2_regs (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] ds_addr,
   input wire logic ds_wr,
   input wire logic ds_rd,
   input wire logic [5:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata_q,
   input wire logic global_irq_en,
   input wire logic [2:0] irq_ack,
   input wire logic timer_tick,
   input wire logic [7:0] counter_value,
   input wire logic match_a_evt,
   input wire logic wrap_max_evt,
   input wire logic bottom_evt,
   input wire logic dual_slope,
   output logic [2:0] irq_req_q,
   output logic match_b_q,
   output logic [7:0] compare_b_q,
   output logic ext_clk_buf_en_q,
   output logic xtal_osc_en_q,
   output logic async_clk_sel_q,
   output logic reinit_q,
   output logic sync_psr_q,
   output logic async_psr_q
);
   typedef struct packed {
      logic [2:0] flags;
      logic [2:0] mask;
      logic [7:0] cmpb;
      logic [7:0] cmpb_tmp;
      logic ext;
      logic as;
      logic ext_buf;
      logic xtal;
      logic sync_hold_mode;
      logic [1:0] psr;
      logic [7:0] rdata;
      logic [2:0] irq;
      logic match_b;
      logic reinit;
   } regs_s;

   localparam regs_s REGS_RST = '{flags: timer2_pkg::RST_FLAGS, mask: timer2_pkg::RST_MASK,
      cmpb: timer2_pkg::RST_BYTE, cmpb_tmp: timer2_pkg::RST_BYTE, ext: 1'b0, as: 1'b0,
      ext_buf: 1'b0, xtal: 1'b1, sync_hold_mode: 1'b0, psr: 2'h0, rdata: timer2_pkg::RST_BYTE,
      irq: 3'h0, match_b: 1'b0, reinit: 1'b0};

   regs_s q;
   regs_s d;
   logic [timer2_pkg::NUM_BUSY-1:0] busy;
   logic [timer2_pkg::NUM_BUSY-1:0] busy_wr;
   logic match_b_evt;
   logic wrap_evt;

   // true when either access path selects the register at data-space offset off
   function automatic logic hit(input logic [15:0] off, input logic [15:0] daddr, input logic dstb,
                                input logic [5:0] iaddr, input logic istb);
      logic io_ok;
      io_ok = istb && (off < timer2_pkg::EXT_BASE); // R16
      hit = (dstb && (daddr == off)) || (io_ok && (({10'h000, iaddr} + timer2_pkg::IO_SHIFT) == off)); // R15
   endfunction

   assign match_b_evt = timer_tick && (counter_value == q.cmpb); // R1
   assign wrap_evt = dual_slope ? bottom_evt : wrap_max_evt; // R7

   // busy bits for the five asynchronously updated registers
   generate
      for (genvar i = 0; i < timer2_pkg::NUM_BUSY; i++) begin : g_busy
         assign busy_wr[i] = hit(timer2_pkg::BUSY_OFFS[i], ds_addr, ds_wr, io_addr, io_wr);
         timer2_busy_slot u_slot (
            .clk(clk),
            .sys_rst(sys_rst),
            .async_mode(q.as),
            .wr(busy_wr[i]),
            .tick(timer_tick),
            .busy_q(busy[i])
         );
      end
   endgenerate

   always_comb begin
      logic [2:0] set;
      logic [2:0] clr;
      logic wr_flags;
      logic wr_mask;
      logic wr_sync;
      logic wr_async;
      set = '0;
      clr = '0;
      d = q;
      wr_flags = hit(timer2_pkg::OFF_FLAGS, ds_addr, ds_wr, io_addr, io_wr);
      wr_mask = hit(timer2_pkg::OFF_MASK, ds_addr, ds_wr, io_addr, io_wr);
      wr_sync = hit(timer2_pkg::OFF_SYNC, ds_addr, ds_wr, io_addr, io_wr);
      wr_async = hit(timer2_pkg::OFF_ASYNC, ds_addr, ds_wr, io_addr, io_wr);

      set[timer2_pkg::BIT_MATCH_B] = match_b_evt; // R6
      set[timer2_pkg::BIT_MATCH_A] = match_a_evt; // R5
      set[timer2_pkg::BIT_WRAP] = wrap_evt; // R7
      clr = irq_ack; // R8
      if (wr_flags) begin
         clr = clr | wdata[2:0]; // R8
      end
      // an event in the clearing cycle wins
      d.flags = (q.flags & ~clr) | set;
      d.match_b = match_b_evt; // R1

      if (wr_mask) begin
         d.mask = wdata[2:0];
      end
      d.irq = d.flags & d.mask & {3{global_irq_en}}; // R2 R3 R4

      // compare b: direct in sync mode, staged and moved on the tick in async mode
      if (busy[timer2_pkg::BUSY_CMPB] && timer_tick) begin
         d.cmpb = q.cmpb_tmp; // R13
      end
      if (busy_wr[timer2_pkg::BUSY_CMPB]) begin
         if (q.as) begin
            d.cmpb_tmp = wdata; // R13
         end else begin
            d.cmpb = wdata; // R1
         end
      end

      d.reinit = 1'b0;
      if (wr_async) begin
         d.ext = wdata[timer2_pkg::BIT_EXT];
         d.as = wdata[timer2_pkg::BIT_AS]; // R11
         if (wdata[timer2_pkg::BIT_AS] != q.as) begin
            d.reinit = 1'b1; // R12
            d.cmpb = timer2_pkg::RST_BYTE; // R12
            d.cmpb_tmp = timer2_pkg::RST_BYTE;
         end
      end
      d.ext_buf = d.ext && d.as; // R9
      d.xtal = !d.ext; // R9

      if (wr_sync) begin
         d.sync_hold_mode = wdata[timer2_pkg::BIT_TSM];
         if (wdata[timer2_pkg::BIT_TSM]) begin
            d.psr = {wdata[timer2_pkg::BIT_PSR_ASY], wdata[timer2_pkg::BIT_PSR_SYNC]}; // R17
         end else if (q.sync_hold_mode) begin
            d.psr = 2'h0; // R18
         end else begin
            d.psr = {wdata[timer2_pkg::BIT_PSR_ASY], wdata[timer2_pkg::BIT_PSR_SYNC]}; // R19
         end
      end else if (!q.sync_hold_mode) begin
         d.psr = 2'h0; // R19
      end

      if (ds_rd || io_rd) begin
         d.rdata = timer2_pkg::RST_BYTE;
         if (hit(timer2_pkg::OFF_FLAGS, ds_addr, ds_rd, io_addr, io_rd)) begin
            d.rdata = {5'h00, q.flags};
         end else if (hit(timer2_pkg::OFF_MASK, ds_addr, ds_rd, io_addr, io_rd)) begin
            d.rdata = {5'h00, q.mask};
         end else if (hit(timer2_pkg::OFF_CMPB, ds_addr, ds_rd, io_addr, io_rd)) begin
            d.rdata = q.cmpb;
         end else if (hit(timer2_pkg::OFF_ASYNC, ds_addr, ds_rd, io_addr, io_rd)) begin
            d.rdata = {1'b0, q.ext, q.as, busy};
         end else if (hit(timer2_pkg::OFF_SYNC, ds_addr, ds_rd, io_addr, io_rd)) begin
            d.rdata = {q.sync_hold_mode, 5'h00, q.psr};
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= REGS_RST;
      end else begin
         q <= d;
      end
   end

   assign rdata_q = q.rdata;
   assign irq_req_q = q.irq;
   assign match_b_q = q.match_b;
   assign compare_b_q = q.cmpb;
   assign ext_clk_buf_en_q = q.ext_buf;
   assign xtal_osc_en_q = q.xtal;
   assign async_clk_sel_q = q.as;
   assign reinit_q = q.reinit;
   assign sync_psr_q = q.psr[timer2_pkg::BIT_PSR_SYNC];
   assign async_psr_q = q.psr[timer2_pkg::BIT_PSR_ASY];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_match_b_flag: assert property (match_b_evt |=> q.flags[2] && match_b_q) // R6
      else $error("compare b match did not set flag and pulse");
   a_match_b_value: assert property (match_b_q |-> $past(counter_value) == $past(compare_b_q)) // R1
      else $error("match b pulse without equal counter");
   a_match_a_flag: assert property (match_a_evt |=> q.flags[1]) // R5
      else $error("compare a match lost");
   a_wrap_bottom: assert property (dual_slope && bottom_evt |=> q.flags[0]) // R7
      else $error("bottom event did not set wrap flag");
   a_ack_clear: assert property (irq_ack[0] && !wrap_evt && !(ds_wr || io_wr) |=> !q.flags[0]) // R8
      else $error("vector ack did not clear wrap flag");
   a_irq_b_gate: assert property (irq_req_q[2] |-> $past(global_irq_en) && q.mask[2] && q.flags[2]) // R2
      else $error("compare b request without enables");
   a_irq_a_gate: assert property (q.flags[1] && q.mask[1] && global_irq_en && irq_ack == 3'h0
      && !(ds_wr || io_wr) |=> irq_req_q[1]) // R3
      else $error("compare a request missing");
   a_irq_wrap_gate: assert property (!global_irq_en |=> irq_req_q[0] == 1'b0) // R4
      else $error("wrap request while globally disabled");
   a_ext_buffer: assert property (ext_clk_buf_en_q |-> async_clk_sel_q && !xtal_osc_en_q) // R9
      else $error("external buffer enabled without async select");
   a_reinit_pulse: assert property ($changed(async_clk_sel_q) |-> reinit_q ##1 !reinit_q) // R12
      else $error("async select change not flagged");
   a_busy_async: assert property (q.as && busy_wr[2] |=> busy[2] [*1] ##0 q.as) // R13
      else $error("async compare b write did not set busy");
   a_busy_sync_mode: assert property (!q.as |=> busy == 5'h00) // R13
      else $error("busy set in sync clock mode");
   a_io_decode: assert property (io_wr && !ds_wr && io_addr == 6'h17 && wdata[0] && !wrap_evt
      |=> !q.flags[0]) // R15
      else $error("short i/o write missed the flag register");
   a_io_ext_block: assert property (io_wr && !ds_wr |=> q.mask == $past(q.mask)) // R16
      else $error("short i/o write reached extended space");
   a_tsm_hold: assert property (q.sync_hold_mode && !hit(timer2_pkg::OFF_SYNC, ds_addr, ds_wr, io_addr, io_wr)
      |=> {async_psr_q, sync_psr_q} == $past({async_psr_q, sync_psr_q})) // R17
      else $error("prescaler reset changed in sync mode");
   a_tsm_release: assert property (q.sync_hold_mode && hit(timer2_pkg::OFF_SYNC, ds_addr, ds_wr, io_addr, io_wr)
      && !wdata[7] |=> !sync_psr_q && !async_psr_q) // R18
      else $error("sync mode release left resets set");
   a_psr_self_clear: assert property (sync_psr_q && !q.sync_hold_mode
      && !hit(timer2_pkg::OFF_SYNC, ds_addr, ds_wr, io_addr, io_wr) |=> !sync_psr_q) // R19
      else $error("sync prescaler reset did not self-clear");

   c_irq_b: cover property (match_b_evt ##1 irq_req_q[2]);
   c_async_commit: cover property (busy[2] ##1 !busy[2]);
   c_tsm_cycle: cover property (q.sync_hold_mode && sync_psr_q ##[1:20] !q.sync_hold_mode);
   c_io_flag_clear: cover property (io_wr && io_addr == 6'h17);
endmodule // timer2_regs

// file: timer2_regs_tb.sv
// testbench for timer2_regs: register map, flags, irq gating, async busy, sync prescaler resets
// assumes timer2_pkg is compiled first; the bench plays both the cpu and the counting engine
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module timer2_regs_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] ds_addr = 16'h0000;
   logic ds_wr = 1'b0;
   logic ds_rd = 1'b0;
   logic [5:0] io_addr = 6'h00;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic global_irq_en = 1'b0;
   logic [2:0] irq_ack = 3'h0;
   logic timer_tick = 1'b0;
   logic [7:0] counter_value = 8'h00;
   logic match_a_evt = 1'b0;
   logic wrap_max_evt = 1'b0;
   logic bottom_evt = 1'b0;
   logic dual_slope = 1'b0;
   logic [7:0] rdata_q, compare_b_q, val;
   logic [2:0] irq_req_q;
   logic match_b_q, ext_clk_buf_en_q, xtal_osc_en_q, async_clk_sel_q, reinit_q, sync_psr_q, async_psr_q;
   logic [11:0] notes[$];
   logic [11:0] nt;
   string nm[7] = '{"rdata_q", "irq_req_q", "match_b_q", "compare_b_q", "clock_select", "prescaler_resets",
      "reinit_q"};
   int n_errors = 0;
   int comparisons = 0;
   int seed = 28468;
   timer2_regs i_dut (.clk, .sys_rst, .ds_addr, .ds_wr, .ds_rd, .io_addr, .io_wr, .io_rd, .wdata, .rdata_q,
      .global_irq_en, .irq_ack, .timer_tick, .counter_value, .match_a_evt, .wrap_max_evt, .bottom_evt,
      .dual_slope, .irq_req_q, .match_b_q, .compare_b_q, .ext_clk_buf_en_q, .xtal_osc_en_q, .async_clk_sel_q,
      .reinit_q, .sync_psr_q, .async_psr_q);
   always #2.5 clk = ~clk;
   function automatic logic [7:0] seen(input logic [3:0] s);
      case (s)
         4'h0: return rdata_q;
         4'h1: return {5'h00, irq_req_q};
         4'h2: return {7'h00, match_b_q};
         4'h3: return compare_b_q;
         4'h4: return {5'h00, ext_clk_buf_en_q, xtal_osc_en_q, async_clk_sel_q};
         4'h6: return {7'h00, reinit_q};
         default: return {6'h00, sync_psr_q, async_psr_q};
      endcase
   endfunction
   // notes are taken at the falling edge, after the rising edge that produced them has settled
   always @(negedge clk) begin
      while (notes.size() > 0) begin
         nt = notes.pop_front();
         `CHK(nm[nt[11:8]], nt[7:0], seen(nt[11:8]))
      end
   end
   task automatic note(input logic [3:0] s, input logic [7:0] e);
      notes.push_back({s, e});
   endtask
   task automatic acc(input logic io, input logic rd, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      if (io) begin
         io_wr <= ~rd;
         io_rd <= rd;
         io_addr <= 6'(a - timer2_pkg::IO_SHIFT);
      end else begin
         ds_wr <= ~rd;
         ds_rd <= rd;
         ds_addr <= a;
      end
      wdata <= d;
      @(posedge clk);
      {io_wr, io_rd, ds_wr, ds_rd} <= 4'h0;
      if (rd) begin
         note(4'h0, d);
      end
   endtask
   // one-cycle pulse on {tick, match a, wrap at max, bottom}
   task automatic pulse(input logic [3:0] v);
      @(posedge clk);
      {timer_tick, match_a_evt, wrap_max_evt, bottom_evt} <= v;
      @(posedge clk);
      {timer_tick, match_a_evt, wrap_max_evt, bottom_evt} <= 4'h0;
   endtask
   task automatic stop_test();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      stop_test();
   end
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      note(4'h4, 8'h02);
      for (int i = 0; i < timer2_pkg::NUM_BUSY; i++) begin
         acc(1'b0, 1'b1, timer2_pkg::BUSY_OFFS[i], 8'h00);
      end
      acc(1'b0, 1'b1, timer2_pkg::OFF_FLAGS, 8'h00);
      acc(1'b0, 1'b1, timer2_pkg::OFF_MASK, 8'h00);
      acc(1'b0, 1'b1, timer2_pkg::OFF_ASYNC, 8'h00);
      acc(1'b1, 1'b1, timer2_pkg::OFF_SYNC, 8'h00);
      acc(1'b0, 1'b1, 16'h0100, 8'h00);
      val = 8'($random(seed));
      acc(1'b0, 1'b0, timer2_pkg::OFF_CMPB, val);
      note(4'h3, val);
      acc(1'b0, 1'b1, timer2_pkg::OFF_CMPB, val);
      counter_value <= val ^ 8'h01;
      pulse(4'h8);
      note(4'h2, 8'h00);
      counter_value <= val;
      pulse(4'h8);
      note(4'h2, 8'h01);
      acc(1'b1, 1'b1, timer2_pkg::OFF_FLAGS, 8'h04);
      acc(1'b1, 1'b0, timer2_pkg::OFF_FLAGS, 8'h04);
      acc(1'b1, 1'b1, timer2_pkg::OFF_FLAGS, 8'h00);
      pulse(4'h4);
      pulse(4'h2);
      acc(1'b0, 1'b1, timer2_pkg::OFF_FLAGS, 8'h03);
      dual_slope <= 1'b1;
      acc(1'b1, 1'b0, timer2_pkg::OFF_FLAGS, 8'h03);
      pulse(4'h2);
      pulse(4'h1);
      acc(1'b1, 1'b0, timer2_pkg::OFF_FLAGS, 8'h00);
      acc(1'b1, 1'b1, timer2_pkg::OFF_FLAGS, 8'h01);
      irq_ack <= 3'h1;
      @(posedge clk);
      irq_ack <= 3'h0;
      acc(1'b1, 1'b1, timer2_pkg::OFF_FLAGS, 8'h00);
      pulse(4'h4);
      pulse(4'h1);
      pulse(4'h8);
      global_irq_en <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         acc(1'b0, 1'b0, timer2_pkg::OFF_MASK, 8'h01 << i);
         note(4'h1, 8'h01 << i);
      end
      acc(1'b1, 1'b0, timer2_pkg::OFF_MASK, 8'h07);
      acc(1'b0, 1'b1, timer2_pkg::OFF_MASK, 8'h04);
      global_irq_en <= 1'b0;
      @(posedge clk);
      note(4'h1, 8'h00);
      // vector acks for compare b and compare a while all three flags stand
      irq_ack <= 3'h6;
      @(posedge clk);
      irq_ack <= 3'h0;
      acc(1'b0, 1'b1, timer2_pkg::OFF_FLAGS, 8'h01);
      acc(1'b0, 1'b0, timer2_pkg::OFF_ASYNC, 8'h40);
      note(4'h4, 8'h00);
      note(4'h6, 8'h00);
      acc(1'b0, 1'b0, timer2_pkg::OFF_ASYNC, 8'h60);
      note(4'h4, 8'h05);
      note(4'h6, 8'h01);
      @(posedge clk);
      note(4'h3, 8'h00);
      note(4'h6, 8'h00);
      val = 8'($random(seed));
      for (int i = 0; i < timer2_pkg::NUM_BUSY; i++) begin
         acc(1'b0, 1'b0, timer2_pkg::BUSY_OFFS[i], val);
      end
      acc(1'b0, 1'b1, timer2_pkg::OFF_ASYNC, 8'h7f);
      note(4'h3, 8'h00);
      pulse(4'h8);
      acc(1'b0, 1'b1, timer2_pkg::OFF_ASYNC, 8'h60);
      acc(1'b0, 1'b1, timer2_pkg::OFF_CMPB, val);
      acc(1'b1, 1'b0, timer2_pkg::OFF_SYNC, 8'h83);
      note(4'h5, 8'h03);
      repeat (3) @(posedge clk);
      note(4'h5, 8'h03);
      acc(1'b1, 1'b0, timer2_pkg::OFF_SYNC, 8'h00);
      note(4'h5, 8'h00);
      acc(1'b0, 1'b0, timer2_pkg::OFF_SYNC, 8'h01);
      note(4'h5, 8'h02);
      @(posedge clk);
      note(4'h5, 8'h00);
      repeat (2) @(posedge clk);
      stop_test();
   end
endmodule // timer2_regs_tb
